// [hw/imct_ctrl.sv]
/*
 Interrupt mode control for interrupt numbers 36 to 43: two
 configuration registers, one byte lane per source, an event status
 register, and per-source routing to the processor or to a DMA
 channel.
 Assumes a single-cycle register port on CORE_CLK, and source
 requests produced by peripheral logic on the same clock.
*/
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module imct_ctrl (
   input  wire logic        CORE_CLK,
   input  wire logic        RST_N,
   input  wire logic [31:0] REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [31:0] REG_RDATA,
   input  wire logic [7:0]  SRC_REQ,
   output logic      [7:0]  IRQ_REQ,
   output logic      [23:0] IRQ_LEVEL,
   output logic      [7:0]  DMA_START
);

   typedef struct packed {
      logic [31:0] cfg36;
      logic [31:0] cfg40;
      logic [7:0]  evt;
      logic [31:0] rdata;
      logic [7:0]  irq_req;
      logic [23:0] irq_level;
      logic [7:0]  dma_start;
   } imct_state_t;

   imct_state_t state_r;
   imct_state_t state_nxt;

   logic [7:0]  lane_irq;
   logic [7:0]  lane_dma;
   logic [23:0] lane_sel;
   logic [63:0] cfg_all;

   // Lane n of the concatenation serves interrupt number 36 + n
   function automatic logic [7:0] lane_of(
      input logic [63:0] regs,
      input int          idx
   );
      lane_of = regs[idx*imct_pkg::LANE_W +: imct_pkg::LANE_W];
   endfunction

   // Reserved lane bits are dropped on the way in
   function automatic logic [31:0] masked_write(
      input logic [31:0] wdata
   );
      logic [31:0] m;
      m = {imct_pkg::SRC_PER_REG{imct_pkg::LANE_WR_MASK}};
      masked_write = wdata & m;
   endfunction

   function automatic logic [7:0] chan_onehot(
      input logic [2:0] ch
   );
      chan_onehot = 8'h01 << ch;
   endfunction

   // 36..39 in the first word, 40..43 in the second
   assign cfg_all = {state_r.cfg40, state_r.cfg36};

   genvar g;
   generate
      for (g = 0; g < imct_pkg::NUM_SRC; g++) begin : g_lane
         imct_lane u_lane (
            .clk       (CORE_CLK),
            .rst_n     (RST_N),
            .cfg       (lane_of(cfg_all, g)),
            .req       (SRC_REQ[g]),
            .irq_pulse (lane_irq[g]),
            .dma_pulse (lane_dma[g]),
            .sel       (lane_sel[g*imct_pkg::LVL_W +: imct_pkg::LVL_W])
         );
      end
   endgenerate

   always_comb begin
      logic [7:0] dma_acc;
      logic [7:0] lane;
      logic       hit;
      dma_acc   = 8'h00;
      lane      = 8'h00;
      hit       = 1'b0;
      state_nxt = state_r;

      // Register writes
      if (REG_WR) begin
         if (REG_ADDR == imct_pkg::ADDR_SRC36_39) begin
            state_nxt.cfg36 = masked_write(REG_WDATA);
         end else if (REG_ADDR == imct_pkg::ADDR_SRC40_43) begin
            state_nxt.cfg40 = masked_write(REG_WDATA);
         end else if (REG_ADDR == imct_pkg::ADDR_EVT_STAT) begin
            // Write one to clear
            state_nxt.evt = state_r.evt & ~REG_WDATA[7:0];
         end
      end

      // A new event beats a clear in the same cycle
      state_nxt.evt = state_nxt.evt | lane_irq | lane_dma;

      // Read data stand only in the cycle after the strobe
      state_nxt.rdata = 32'h0000_0000;
      if (REG_RD) begin
         if (REG_ADDR == imct_pkg::ADDR_SRC36_39) begin
            state_nxt.rdata = state_r.cfg36;
         end else if (REG_ADDR == imct_pkg::ADDR_SRC40_43) begin
            state_nxt.rdata = state_r.cfg40;
         end else if (REG_ADDR == imct_pkg::ADDR_EVT_STAT) begin
            state_nxt.rdata = {24'h00_0000, state_r.evt};
         end
      end

      // Processor requests carry the configured level
      state_nxt.irq_req = lane_irq;
      for (int i = 0; i < imct_pkg::NUM_SRC; i++) begin
         lane = lane_of(cfg_all, i);
         hit  = lane_irq[i];
         state_nxt.irq_level[i*imct_pkg::LVL_W +: imct_pkg::LVL_W] =
            hit ? lane[imct_pkg::LVL_HI:imct_pkg::LVL_LO] : 3'h0;
         if (lane_dma[i]) begin
            // Several sources may share a channel; their pulses merge
            dma_acc = dma_acc
               | chan_onehot(lane_sel[i*imct_pkg::LVL_W +:
                                      imct_pkg::LVL_W]);
         end
      end
      state_nxt.dma_start = dma_acc;
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_r.cfg36     <= imct_pkg::CFG_RESET;
         state_r.cfg40     <= imct_pkg::CFG_RESET;
         state_r.evt       <= imct_pkg::STAT_RESET;
         state_r.rdata     <= 32'h0000_0000;
         state_r.irq_req   <= 8'h00;
         state_r.irq_level <= 24'h00_0000;
         state_r.dma_start <= 8'h00;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign REG_RDATA = state_r.rdata;
   assign IRQ_REQ   = state_r.irq_req;
   assign IRQ_LEVEL = state_r.irq_level;
   assign DMA_START = state_r.dma_start;

endmodule
`default_nettype wire

// [include/imct_pkg.sv]
/*
 Constants, field layout and types shared by the interrupt mode
 control block for interrupt numbers 36 to 43.
 Assumes a 32-bit register port with byte addresses.
*/
`default_nettype none
package imct_pkg;

   // Sources and lanes
   localparam int NUM_SRC       = 8;
   localparam int SRC_PER_REG   = 4;
   localparam int LANE_W        = 8;
   localparam int DATA_W        = 32;
   localparam int ADDR_W        = 32;
   localparam int LVL_W         = 3;

   // Register addresses
   localparam logic [31:0] ADDR_SRC36_39  = 32'hFFFF_E024;
   localparam logic [31:0] ADDR_SRC40_43  = 32'hFFFF_E028;
   localparam logic [31:0] ADDR_EVT_STAT  = 32'hFFFF_E0F8;

   // Reset values
   localparam logic [31:0] CFG_RESET      = 32'h0000_0000;
   localparam logic [7:0]  STAT_RESET     = 8'h00;

   // Writable bits of one lane; bits 7 and 3 read zero
   localparam logic [7:0]  LANE_WR_MASK   = 8'h77;

   // Field positions inside a lane
   localparam int ACT_HI        = 6;
   localparam int ACT_LO        = 5;
   localparam int DMA_SEL_BIT   = 4;
   localparam int LVL_HI        = 2;
   localparam int LVL_LO        = 0;

   // Field encodings
   localparam logic [1:0]  ACT_RISING     = 2'h3;
   localparam logic [2:0]  LVL_DISABLED   = 3'h0;

   // How a lane routes its detected request
   typedef enum logic [1:0] {
      IMCT_ROUTE_OFF = 2'h0,
      IMCT_ROUTE_CPU = 2'h1,
      IMCT_ROUTE_DMA = 2'h3
   } imct_route_t;

endpackage
`default_nettype wire

// [hw/imct_lane.sv]
/*
 One source lane: decodes the lane byte, detects the rising edge of
 the source request and issues a CPU or DMA pulse.
 Assumes the request comes from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module imct_lane (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] cfg,
   input  wire logic       req,
   output logic            irq_pulse,
   output logic            dma_pulse,
   output logic [2:0]      sel
);

   typedef struct packed {
      logic       prev;
      logic       irq_pulse;
      logic       dma_pulse;
      logic [2:0] sel;
   } imct_lane_state_t;

   imct_lane_state_t state_r;
   imct_lane_state_t state_nxt;
   imct_pkg::imct_route_t route;
   logic                  rise;

   always_comb begin
      rise = req & ~state_r.prev;
      // Only the rising-edge setting detects anything at all
      if (cfg[imct_pkg::ACT_HI:imct_pkg::ACT_LO]
          != imct_pkg::ACT_RISING) begin
         route = imct_pkg::IMCT_ROUTE_OFF;
      end else if (cfg[imct_pkg::DMA_SEL_BIT]) begin
         route = imct_pkg::IMCT_ROUTE_DMA;
      end else if (cfg[imct_pkg::LVL_HI:imct_pkg::LVL_LO]
                   == imct_pkg::LVL_DISABLED) begin
         route = imct_pkg::IMCT_ROUTE_OFF;
      end else begin
         route = imct_pkg::IMCT_ROUTE_CPU;
      end
      state_nxt           = state_r;
      state_nxt.prev      = req;
      state_nxt.sel       = cfg[imct_pkg::LVL_HI:imct_pkg::LVL_LO];
      // A DMA-routed request never reaches the processor
      state_nxt.irq_pulse = rise
                            & (route == imct_pkg::IMCT_ROUTE_CPU);
      state_nxt.dma_pulse = rise
                            & (route == imct_pkg::IMCT_ROUTE_DMA);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign irq_pulse = state_r.irq_pulse;
   assign dma_pulse = state_r.dma_pulse;
   assign sel       = state_r.sel;

endmodule
`default_nettype wire

// [test/imct_src_model.sv]
/* Source-side model: peripheral request lines of sources 36 to 43.
   Assumes the bench calls pulse between clock edges. */
`timescale 1ns/1ps
`default_nettype none
module imct_src_model (
   input  wire logic       clk,
   output logic      [7:0] src_req
);
   initial src_req = 8'h00;
   // Held high for n cycles; a long hold must still give one event
   task automatic pulse(input logic [7:0] m, input int n);
      @(posedge clk);
      src_req <= m;
      repeat (n) @(posedge clk);
      src_req <= 8'h00;
   endtask
endmodule
`default_nettype wire

// [test/imct_ctrl_chk.sv]
/* Port checker for imct_ctrl.
   Assumes a bind to the top module. */
`timescale 1ns/1ps
`default_nettype none
module imct_ctrl_chk (
   input wire logic        CORE_CLK,
   input wire logic        RST_N,
   input wire logic [31:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [31:0] REG_RDATA,
   input wire logic [7:0]  SRC_REQ,
   input wire logic [7:0]  IRQ_REQ,
   input wire logic [23:0] IRQ_LEVEL,
   input wire logic [7:0]  DMA_START
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   sequence s_wr; REG_WR && REG_ADDR == imct_pkg::ADDR_SRC40_43; endsequence
   sequence s_rd; REG_RD && REG_ADDR == imct_pkg::ADDR_SRC40_43; endsequence
   property p_wr_rd;
      s_wr ##1 s_rd |=> REG_RDATA == ($past(REG_WDATA, 2) & 32'h7777_7777);
   endproperty
   // Status register is excluded: its bits 7 and 3 are live
   property p_rsvd;
      REG_RD && REG_ADDR != imct_pkg::ADDR_EVT_STAT |=>
         (REG_RDATA & 32'h8888_8888) == 32'h0;
   endproperty
   property p_idle; !REG_RD |=> REG_RDATA == 32'h0; endproperty
   property p_lvl0; IRQ_REQ == 8'h00 |-> IRQ_LEVEL == 24'h0; endproperty
   property p_lvl; IRQ_REQ[0] |-> IRQ_LEVEL[2:0] != 3'h0; endproperty
   property p_one; IRQ_REQ[0] |=> !IRQ_REQ[0]; endproperty
   property p_irq;
      (IRQ_REQ & ~($past(SRC_REQ, 2) & ~$past(SRC_REQ, 3))) == 8'h00;
   endproperty
   property p_dma;
      DMA_START != 8'h00 |-> ($past(SRC_REQ, 2) & ~$past(SRC_REQ, 3)) != 8'h0;
   endproperty
   a_wr_rd: assert property (p_wr_rd) else $error("readback");
   a_rsvd: assert property (p_rsvd) else $error("spare bits");
   a_idle: assert property (p_idle) else $error("rdata idle");
   a_lvl0: assert property (p_lvl0) else $error("level idle");
   a_lvl: assert property (p_lvl) else $error("level zero");
   a_one: assert property (p_one) else $error("long pulse");
   a_irq: assert property (p_irq) else $error("irq cause");
   a_dma: assert property (p_dma) else $error("dma cause");
endmodule
`default_nettype wire

// [test/test_imct_ctrl.sv]
/* Bench for imct_ctrl: register tasks and source pulses with checks.
   Assumes the package, model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_imct_ctrl;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [31:0] addr = 32'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rdata;
   logic [7:0]  src, irq, dma;
   logic [23:0] lvl, exp_lvl;
   int          bad_count = 0;
   int          tests_run = 0;
   always #2.5 clk = ~clk;
   imct_ctrl i_imct_ctrl (.CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
      .SRC_REQ(src), .IRQ_REQ(irq), .IRQ_LEVEL(lvl), .DMA_START(dma));
   imct_src_model u_src (.clk(clk), .src_req(src));
   task automatic chk(input logic [39:0] g, input logic [39:0] e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Optional write, then a read with no gap
   task automatic acc(input logic w, input logic [31:0] a, d, e);
      if (w) begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
      end
      @(posedge clk);
      addr <= a;
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk({8'h00, rdata}, {8'h00, e});
   endtask
   task automatic fire(input logic [7:0] m, input logic [39:0] e);
      fork
         u_src.pulse(m, 3);
         begin
            repeat (6) begin
               @(negedge clk);
               if ((irq | dma) !== 8'h00) break;
            end
            chk({irq, lvl, dma}, e);
         end
      join
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      bad_count++;
      wrap_up();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      acc(1'b0, imct_pkg::ADDR_SRC36_39, 32'h0, 32'h0);
      acc(1'b0, imct_pkg::ADDR_SRC40_43, 32'h0, 32'h0);
      fire(8'hFF, 40'h0);
      acc(1'b1, 32'hFFFF_E02C, 32'hFFFF_FFFF, 32'h0);
      acc(1'b1, imct_pkg::ADDR_SRC40_43, 32'hFFFF_FFFF, 32'h7777_7777);
      acc(1'b1, imct_pkg::ADDR_SRC36_39, 32'h6463_6261, 32'h6463_6261);
      acc(1'b1, imct_pkg::ADDR_SRC40_43, 32'hE9E7_E6E5, 32'h6167_6665);
      for (int n = 0; n < 8; n++) exp_lvl[3*n +: 3] = 3'((n % 7) + 1);
      fire(8'hFF, {8'hFF, exp_lvl, 8'h00});
      acc(1'b1, imct_pkg::ADDR_SRC36_39, 32'h6060_6060, 32'h6060_6060);
      acc(1'b1, imct_pkg::ADDR_SRC40_43, 32'h4545_2525, 32'h4545_2525);
      fire(8'hFF, 40'h0);
      acc(1'b1, imct_pkg::ADDR_SRC36_39, 32'h7475_7677, 32'h7475_7677);
      acc(1'b1, imct_pkg::ADDR_SRC40_43, 32'h7071_7273, 32'h7071_7273);
      for (int i = 0; i < 8; i++) fire(8'h01 << i, {32'h0, 8'h80 >> i});
      // Every source has fired by now; ones clear only their own bits
      acc(1'b0, imct_pkg::ADDR_EVT_STAT, 32'h0, 32'h0000_00FF);
      acc(1'b1, imct_pkg::ADDR_EVT_STAT, 32'h0000_000F, 32'h0000_00F0);
      wrap_up();
   end
endmodule
bind imct_ctrl imct_ctrl_chk i_imct_ctrl_chk (.CORE_CLK(CORE_CLK),
   .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
   .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .SRC_REQ(SRC_REQ), .IRQ_REQ(IRQ_REQ), .IRQ_LEVEL(IRQ_LEVEL),
   .DMA_START(DMA_START));
`default_nettype wire
